// File: include/ipo_defines.svh
`ifndef IPO_DEFINES_SVH
`define IPO_DEFINES_SVH

// ----------------------------------------------------------------
// Descriptor field layout (bit positions in the 512-bit line)
// ----------------------------------------------------------------
`define IPO_ON_BIT        256
`define IPO_SN_BIT        257
`define IPO_NV_LSB        272
`define IPO_NOTICE_DESTINATION_LSB      288

// ----------------------------------------------------------------
// Notification message attributes
// ----------------------------------------------------------------
`define IPO_DLV_FIXED     3'h0
`define IPO_REDIR_CLEAR   1'h0
`define IPO_TRIG_EDGE     1'h0
`define IPO_LEVEL_ASSERT  1'h1

// ----------------------------------------------------------------
// Register byte offsets and reset values
// ----------------------------------------------------------------
`define IPO_REG_CTRL      6'h00
`define IPO_REG_STAT      6'h04
`define IPO_REG_POSTED    6'h08
`define IPO_REG_NOTICE    6'h0C
`define IPO_REG_SUPP      6'h10
`define IPO_CTRL_EN_BIT   0
`define IPO_CTRL_CLR_BIT  1
`define IPO_CTRL_RST      1'h1

`endif

// File: include/ipo_pkg.sv
package ipo_pkg;

  typedef enum logic {
    IPO_MEM_RD_LOCK,
    IPO_MEM_WR_UNLOCK
  } ipo_mem_cmd_e;

  typedef enum logic [3:0] {
    IPO_IDLE,
    IPO_DRAIN,
    IPO_RD,
    IPO_RDW,
    IPO_WR,
    IPO_GO,
    IPO_NOTE,
    IPO_NOTEW,
    IPO_DONE
  } ipo_state_e;

  typedef struct packed {
    logic        posted;
    logic        urgent;
    logic [7:0]  vector;
    logic [57:0] desc_line;
    logic [31:0] dest;
  } ipo_irq_s;

  typedef struct packed {
    ipo_mem_cmd_e cmd;
    logic [57:0]  line;
    logic [511:0] wdata;
  } ipo_mem_req_s;

  typedef struct packed {
    logic [31:0] dest;
    logic [7:0]  vector;
    logic [2:0]  dlv_mode;
    logic        redir_hint;
    logic        trig_mode;
    logic        trig_level;
  } ipo_msg_s;

  typedef struct packed {
    logic [7:0]  tag;
    logic [63:0] data;
  } ipo_cpl_s;

endpackage

// File: hdl/ipo_order_queue.sv
`timescale 1ns/1ns
module ipo_order_queue (
  input  wire logic            sys_clk_i,
  input  wire logic            resetn_i,
  input  wire logic            in_valid_i,
  input  ipo_pkg::ipo_cpl_s    in_cpl_i,
  output logic                 in_ready_o,
  input  wire logic [7:0]      irq_seq_i,
  input  wire logic [7:0]      done_seq_i,
  output logic                 out_valid_o,
  output ipo_pkg::ipo_cpl_s    out_cpl_o,
  input  wire logic            out_ready_i
);
  import ipo_pkg::*;

  ipo_cpl_s   mem [4];
  logic [7:0] tag [4];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] count;
  logic       push;
  logic       pop;
  logic [7:0] lag;

  // Head may leave once all interrupts taken before it are finished;
  // wrap-safe while fewer than 128 interrupts are in flight.
  assign lag  = done_seq_i - tag[rd_ptr];
  assign pop  = (count != 3'h0) && !lag[7] && (!out_valid_o || out_ready_i);
  assign push = in_valid_i && in_ready_o;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      count <= count + {2'h0, push} - {2'h0, pop};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_cpl_i;
      tag[wr_ptr] <= irq_seq_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_ready_o <= 1'h1;
    end else begin
      in_ready_o <= (count + {2'h0, push} - {2'h0, pop}) < 3'h4;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'h0;
      out_cpl_o   <= '0;
    end else if (pop) begin
      out_valid_o <= 1'h1;
      out_cpl_o   <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'h0;
    end
  end

endmodule // ipo_order_queue

// File: hdl/ipo_regs.sv
`timescale 1ns/1ns
`include "ipo_defines.svh"
module ipo_regs (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [31:0] stat_i,
  input  wire logic [31:0] posted_cnt_i,
  input  wire logic [31:0] notice_cnt_i,
  input  wire logic [31:0] supp_cnt_i,
  output logic             enable_o,
  output logic             clear_o
);
  logic [5:0] byte_addr;
  logic       wr_take;

  assign byte_addr = {avs_address_i, 2'h0};
  // Write lands on the edge where the master sees waitrequest low
  assign wr_take   = avs_write_i && !avs_waitrequest_o;

  // ----------------------------------------------------------------
  // Handshake: one wait cycle per access
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'h1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'h0;
    end else begin
      avs_waitrequest_o <= 1'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      unique case (byte_addr)
        `IPO_REG_CTRL:   avs_readdata_o <= {31'h0, enable_o};
        `IPO_REG_STAT:   avs_readdata_o <= stat_i;
        `IPO_REG_POSTED: avs_readdata_o <= posted_cnt_i;
        `IPO_REG_NOTICE: avs_readdata_o <= notice_cnt_i;
        `IPO_REG_SUPP:   avs_readdata_o <= supp_cnt_i;
        default:         avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control: enable bit, self-clearing counter clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_o <= `IPO_CTRL_RST;
      clear_o  <= 1'h0;
    end else begin
      clear_o <= 1'h0;
      if (wr_take && byte_addr == `IPO_REG_CTRL) begin
        enable_o <= avs_writedata_i[`IPO_CTRL_EN_BIT];
        clear_o  <= avs_writedata_i[`IPO_CTRL_CLR_BIT];
      end
    end
  end

endmodule // ipo_regs

// File: hdl/ipo_engine.sv
`timescale 1ns/1ns
`include "ipo_defines.svh"

module ipo_engine (
  input  wire logic           sys_clk_i,
  input  wire logic           resetn_i,
  input  wire logic [3:0]     avs_address_i,
  input  wire logic           avs_read_i,
  input  wire logic           avs_write_i,
  input  wire logic [31:0]    avs_writedata_i,
  output logic [31:0]         avs_readdata_o,
  output logic                avs_waitrequest_o,
  input  wire logic           pw_issue_i,
  input  wire logic           pw_done_i,
  input  wire logic           irq_valid_i,
  input  ipo_pkg::ipo_irq_s   irq_i,
  output logic                irq_ready_o,
  output logic                mem_req_valid_o,
  output ipo_pkg::ipo_mem_req_s mem_req_o,
  input  wire logic           mem_req_ready_i,
  input  wire logic           mem_rdata_valid_i,
  input  wire logic [511:0]   mem_rdata_i,
  input  wire logic           mem_go_i,
  output logic                msg_valid_o,
  output ipo_pkg::ipo_msg_s   msg_o,
  input  wire logic           msg_ready_i,
  input  wire logic           msg_done_i,
  input  wire logic           cpl_in_valid_i,
  input  ipo_pkg::ipo_cpl_s   cpl_in_i,
  output logic                cpl_in_ready_o,
  output logic                cpl_out_valid_o,
  output ipo_pkg::ipo_cpl_s   cpl_out_o,
  input  wire logic           cpl_out_ready_i
);
  import ipo_pkg::*;

  ipo_state_e   state;
  ipo_state_e   next_state;
  ipo_irq_s     cur;
  logic [511:0] line;
  logic [7:0]   nv;
  logic [31:0]  notice_destination;
  logic         notify;
  logic [7:0]   pw_out;
  logic [7:0]   pw_wait;
  logic [7:0]   irq_seq;
  logic [7:0]   done_seq;
  logic [31:0]  posted_cnt;
  logic [31:0]  notice_cnt;
  logic [31:0]  supp_cnt;
  logic         enable;
  logic         clear;
  logic         accept;
  logic         x_on;
  logic [31:0]  stat;

  assign accept = irq_valid_i && irq_ready_o;
  assign stat   = {16'h0, pw_out, 3'h0, (state != IPO_IDLE), state};

  // Notify decision from the line just read, before any change
  function automatic logic notice_needed(input logic [511:0] d, input logic urgent_qualifier);
    notice_needed = !d[`IPO_ON_BIT] && (urgent_qualifier || !d[`IPO_SN_BIT]);
  endfunction

  assign x_on = notice_needed(mem_rdata_i, cur.urgent);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  ipo_regs u_regs (
    .sys_clk_i         (sys_clk_i),
    .resetn_i          (resetn_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .stat_i            (stat),
    .posted_cnt_i      (posted_cnt),
    .notice_cnt_i      (notice_cnt),
    .supp_cnt_i        (supp_cnt),
    .enable_o          (enable),
    .clear_o           (clear)
  );

  // ----------------------------------------------------------------
  // Read completion ordering queue
  // ----------------------------------------------------------------
  ipo_order_queue u_queue (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (cpl_in_valid_i),
    .in_cpl_i    (cpl_in_i),
    .in_ready_o  (cpl_in_ready_o),
    .irq_seq_i   (irq_seq + {7'h0, accept}),
    .done_seq_i  (done_seq),
    .out_valid_o (cpl_out_valid_o),
    .out_cpl_o   (cpl_out_o),
    .out_ready_i (cpl_out_ready_i)
  );

  // ----------------------------------------------------------------
  // Posted write tracking
  // ----------------------------------------------------------------
  // Posted writes finish in issue order, so counting completions is enough
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pw_out <= 8'h00;
    end else begin
      pw_out <= pw_out + {7'h0, pw_issue_i} - {7'h0, pw_done_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pw_wait <= 8'h00;
    end else if (accept) begin
      pw_wait <= pw_out + {7'h0, pw_issue_i} - {7'h0, pw_done_i};
    end else if (pw_done_i && pw_wait != 8'h00) begin
      pw_wait <= pw_wait - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Posting sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      IPO_IDLE:  if (accept) next_state = IPO_DRAIN;
      IPO_DRAIN: begin
        if (pw_wait == 8'h00) begin
          next_state = cur.posted ? IPO_RD : IPO_NOTE;
        end
      end
      IPO_RD:    if (mem_req_ready_i) next_state = IPO_RDW;
      IPO_RDW:   if (mem_rdata_valid_i) next_state = IPO_WR;
      IPO_WR:    if (mem_req_ready_i) next_state = IPO_GO;
      IPO_GO: begin
        if (mem_go_i) begin
          next_state = notify ? IPO_NOTE : IPO_DONE;
        end
      end
      IPO_NOTE:  if (msg_ready_i) next_state = IPO_NOTEW;
      IPO_NOTEW: if (msg_done_i) next_state = IPO_DONE;
      IPO_DONE:  next_state = IPO_IDLE;
      default:   next_state = IPO_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= IPO_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_ready_o <= 1'h0;
    end else begin
      irq_ready_o <= (next_state == IPO_IDLE) && enable && !accept;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_seq  <= 8'h00;
      done_seq <= 8'h00;
    end else begin
      if (accept) begin
        irq_seq <= irq_seq + 8'h01;
      end
      if (state == IPO_DONE) begin
        done_seq <= done_seq + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Descriptor read-modify-write
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur    <= '0;
      line   <= 512'h0;
      nv     <= 8'h00;
      notice_destination   <= 32'h0000_0000;
      notify <= 1'h0;
    end else if (accept) begin
      cur    <= irq_i;
      notify <= !irq_i.posted;
    end else if (state == IPO_RDW && mem_rdata_valid_i) begin
      line              <= mem_rdata_i;
      line[cur.vector]  <= 1'h1;
      line[`IPO_ON_BIT] <= mem_rdata_i[`IPO_ON_BIT] | x_on;
      nv                <= mem_rdata_i[`IPO_NV_LSB +: 8];
      notice_destination              <= mem_rdata_i[`IPO_NOTICE_DESTINATION_LSB +: 32];
      notify            <= x_on;
    end
  end

  // Locked read then unlocking write keep the update atomic, provided
  // devices cannot write the line and other posters also lock it.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_req_valid_o <= 1'h0;
      mem_req_o       <= '0;
    end else if (next_state == IPO_RD && state != IPO_RD) begin
      mem_req_valid_o <= 1'h1;
      mem_req_o.cmd   <= IPO_MEM_RD_LOCK;
      mem_req_o.line  <= cur.desc_line;
      mem_req_o.wdata <= 512'h0;
    end else if (next_state == IPO_WR && state != IPO_WR) begin
      mem_req_valid_o <= 1'h1;
      mem_req_o.cmd   <= IPO_MEM_WR_UNLOCK;
      mem_req_o.wdata <= mem_rdata_i | (512'h1 << cur.vector)
                         | ({511'h0, x_on} << `IPO_ON_BIT);
    end else if (mem_req_ready_i) begin
      mem_req_valid_o <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Notification / remapped interrupt message
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      msg_valid_o <= 1'h0;
      msg_o       <= '0;
    end else if (next_state == IPO_NOTE && state != IPO_NOTE) begin
      msg_valid_o      <= 1'h1;
      msg_o.dest       <= cur.posted ? notice_destination : cur.dest;
      msg_o.vector     <= cur.posted ? nv : cur.vector;
      msg_o.dlv_mode   <= `IPO_DLV_FIXED;
      msg_o.redir_hint <= `IPO_REDIR_CLEAR;
      msg_o.trig_mode  <= `IPO_TRIG_EDGE;
      msg_o.trig_level <= `IPO_LEVEL_ASSERT;
    end else if (msg_ready_i) begin
      msg_valid_o <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Statistics
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      posted_cnt <= 32'h0000_0000;
      notice_cnt <= 32'h0000_0000;
      supp_cnt   <= 32'h0000_0000;
    end else if (clear) begin
      posted_cnt <= 32'h0000_0000;
      notice_cnt <= 32'h0000_0000;
      supp_cnt   <= 32'h0000_0000;
    end else if (state == IPO_GO && mem_go_i) begin
      posted_cnt <= posted_cnt + 32'h0000_0001;
      if (notify) begin
        notice_cnt <= notice_cnt + 32'h0000_0001;
      end else begin
        supp_cnt <= supp_cnt + 32'h0000_0001;
      end
    end
  end

endmodule // ipo_engine

// File: sim/ipo_engine_asserts.sv
`timescale 1ns/1ns
`include "ipo_defines.svh"
module ipo_engine_asserts (
  input wire logic             sys_clk_i,
  input wire logic             resetn_i,
  input wire logic             pw_issue_i,
  input wire logic             pw_done_i,
  input wire logic             irq_valid_i,
  input ipo_pkg::ipo_irq_s     irq_i,
  input wire logic             irq_ready_o,
  input wire logic             mem_req_valid_o,
  input ipo_pkg::ipo_mem_req_s mem_req_o,
  input wire logic             mem_req_ready_i,
  input wire logic             mem_rdata_valid_i,
  input wire logic [511:0]     mem_rdata_i,
  input wire logic             mem_go_i,
  input wire logic             msg_valid_o,
  input ipo_pkg::ipo_msg_s     msg_o,
  input wire logic             msg_ready_i,
  input wire logic             msg_done_i,
  input wire logic             cpl_in_valid_i,
  input ipo_pkg::ipo_cpl_s     cpl_in_i,
  input wire logic             cpl_in_ready_o,
  input wire logic             cpl_out_valid_o,
  input ipo_pkg::ipo_cpl_s     cpl_out_o
);
  import ipo_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0]   pw_cnt, older, hold_tag;
  logic         pend, hold, msg_pend, wr_pend, irq_acc, cpl_acc, note;
  ipo_irq_s     irq_l;
  logic [511:0] rd_l, exp_w;
  assign irq_acc = irq_valid_i && irq_ready_o;
  assign cpl_acc = cpl_in_valid_i && cpl_in_ready_o;
  assign note    = !rd_l[`IPO_ON_BIT] && (irq_l.urgent || !rd_l[`IPO_SN_BIT]);
  always_comb begin
    exp_w = rd_l;
    exp_w[irq_l.vector] = 1'h1;
    exp_w[`IPO_ON_BIT] = rd_l[`IPO_ON_BIT] || note;
  end
  always_ff @(posedge sys_clk_i) begin
    if (irq_acc) irq_l <= irq_i;
    if (mem_rdata_valid_i) rd_l <= mem_rdata_i;
    if (cpl_acc && !hold) hold_tag <= cpl_in_i.tag;
  end
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pw_cnt   <= 8'h00;
      older    <= 8'h00;
      pend     <= 1'h0;
      hold     <= 1'h0;
      msg_pend <= 1'h0;
      wr_pend  <= 1'h0;
    end else begin
      pw_cnt   <= pw_cnt + {7'h00, pw_issue_i} - {7'h00, pw_done_i};
      if (irq_acc) older <= pw_cnt + {7'h00, pw_issue_i} - {7'h00, pw_done_i};
      else if (pw_done_i && older != 8'h00) older <= older - 8'h01;
      pend     <= irq_acc || (pend && !msg_done_i && !irq_ready_o);
      hold     <= (cpl_acc && (irq_acc || pend)) || (hold && !msg_done_i && !irq_ready_o);
      msg_pend <= (msg_valid_o && msg_ready_i) || (msg_pend && !msg_done_i);
      wr_pend  <= (mem_req_valid_o && mem_req_ready_i && mem_req_o.cmd == IPO_MEM_WR_UNLOCK)
                  || (wr_pend && !mem_go_i);
    end
  end
  property p_pw_order;
    ($rose(mem_req_valid_o) && mem_req_o.cmd == IPO_MEM_RD_LOCK)
      || ($rose(msg_valid_o) && !irq_l.posted) |-> older == 8'h00;
  endproperty
  a_pw_order: assert property (p_pw_order) else $error("irq ahead of older write");
  property p_cpl_hold; hold && cpl_out_valid_o |-> cpl_out_o.tag != hold_tag; endproperty
  a_cpl_hold: assert property (p_cpl_hold) else $error("completion passed irq");
  property p_done_after_note; msg_pend |-> !irq_ready_o; endproperty
  a_done_after_note: assert property (p_done_after_note) else $error("idle early");
  property p_go_before_note; wr_pend |-> !msg_valid_o; endproperty
  a_go_before_note: assert property (p_go_before_note) else $error("notice early");
  property p_wdata;
    mem_req_valid_o && mem_req_o.cmd == IPO_MEM_WR_UNLOCK
      |-> mem_req_o.wdata == exp_w && mem_req_o.line == irq_l.desc_line;
  endproperty
  a_wdata: assert property (p_wdata) else $error("descriptor update wrong");
  property p_note_gate; $rose(msg_valid_o) && irq_l.posted |-> note; endproperty
  a_note_gate: assert property (p_note_gate) else $error("notice not allowed");
  property p_note_due; mem_go_i && irq_l.posted && note |-> ##[1:16] msg_valid_o; endproperty
  a_note_due: assert property (p_note_due) else $error("notice missing");
  property p_msg_fields;
    msg_valid_o |-> msg_o[5:0] == {`IPO_DLV_FIXED, `IPO_REDIR_CLEAR, `IPO_TRIG_EDGE,
      `IPO_LEVEL_ASSERT} && msg_o[45:6] == (irq_l.posted ? {rd_l[`IPO_NOTICE_DESTINATION_LSB +: 32],
      rd_l[`IPO_NV_LSB +: 8]} : {irq_l.dest, irq_l.vector});
  endproperty
  a_msg_fields: assert property (p_msg_fields) else $error("notice fields wrong");
  c_note: cover property (msg_valid_o && msg_ready_i);
  c_quiet: cover property (mem_go_i && !note);
  c_held: cover property (cpl_acc && pend);
endmodule // ipo_engine_asserts
bind ipo_engine ipo_engine_asserts u_ipo_engine_asserts (.*);

// File: sim/ipo_fabric_model.sv
`timescale 1ns/1ns
module ipo_fabric_model (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [7:0]       lat_i,
  input  wire logic             mem_req_valid_i,
  input  ipo_pkg::ipo_mem_req_s mem_req_i,
  output logic                  mem_req_ready_o,
  output logic                  mem_rdata_valid_o,
  output logic [511:0]          mem_rdata_o,
  output logic                  mem_go_o,
  input  wire logic             msg_valid_i,
  input  ipo_pkg::ipo_msg_s     msg_i,
  output logic                  msg_ready_o,
  output logic                  msg_done_o
);
  import ipo_pkg::*;
  // lat_i stretches every answer
  logic [511:0] mem [4];  // Only the locked update and the idle bench touch it
  ipo_msg_s     last_msg;
  int           n_rd = 0, n_msg = 0, n_done = 0, m_cnt, n_cnt;
  logic         m_busy, n_busy, m_rd;
  logic [1:0]   m_line;
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {mem_req_ready_o, mem_rdata_valid_o, mem_go_o, msg_ready_o, msg_done_o} <= 5'h00;
      {m_busy, n_busy} <= 2'h0;
      m_cnt <= 0;
      n_cnt <= 0;
      mem_rdata_o <= 512'h0;
    end else begin
      {mem_req_ready_o, mem_rdata_valid_o, mem_go_o, msg_ready_o, msg_done_o} <= 5'h00;
      mem_rdata_o <= ~mem_rdata_o;  // Idle data toggles
      if (mem_req_valid_i && mem_req_ready_o) begin
        m_busy <= 1'h1;
        m_cnt <= 0;
        m_rd <= mem_req_i.cmd == IPO_MEM_RD_LOCK;
        m_line <= mem_req_i.line[1:0];
        if (mem_req_i.cmd == IPO_MEM_WR_UNLOCK) mem[mem_req_i.line[1:0]] <= mem_req_i.wdata;
      end else if (m_busy) begin
        m_cnt <= m_cnt + 1;
        if (m_cnt >= int'(lat_i)) begin
          m_busy <= 1'h0;
          m_cnt <= 0;
          mem_rdata_valid_o <= m_rd;
          mem_go_o <= !m_rd;
          if (m_rd) mem_rdata_o <= mem[m_line];
          if (m_rd) n_rd <= n_rd + 1;
        end
      end else if (mem_req_valid_i) begin
        m_cnt <= m_cnt + 1;
        mem_req_ready_o <= m_cnt >= int'(lat_i);
      end
      if (msg_valid_i && msg_ready_o) begin
        n_busy <= 1'h1;
        n_cnt <= 0;
        last_msg <= msg_i;
        n_msg <= n_msg + 1;
      end else if (n_busy) begin
        n_cnt <= n_cnt + 1;
        if (n_cnt >= int'(lat_i)) begin
          n_busy <= 1'h0;
          n_cnt <= 0;
          msg_done_o <= 1'h1;
          n_done <= n_done + 1;
        end
      end else if (msg_valid_i) begin
        n_cnt <= n_cnt + 1;
        msg_ready_o <= n_cnt >= int'(lat_i);
      end
    end
  end
endmodule // ipo_fabric_model

// File: sim/interrupt_posting_ordering_test.sv
`timescale 1ns/1ns
`include "ipo_defines.svh"
module interrupt_posting_ordering_test;
  import ipo_pkg::*;
  logic         sys_clk_i = 1'h0, resetn_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [3:0]   avs_address_i = 4'h0;
  logic [31:0]  avs_writedata_i = 32'h0, avs_readdata_o;
  logic         avs_waitrequest_o, pw_issue_i = 1'h0, pw_done_i = 1'h0, irq_valid_i = 1'h0;
  logic         irq_ready_o, mem_req_valid_o, mem_req_ready_i, mem_rdata_valid_i, mem_go_i;
  logic         msg_valid_o, msg_ready_i, msg_done_i, cpl_in_valid_i = 1'h0, cpl_in_ready_o;
  logic         cpl_out_valid_o, cpl_out_ready_i = 1'h0;
  logic [511:0] mem_rdata_i;
  logic [7:0]   lat = 8'h00;
  ipo_irq_s     irq_i = '0;
  ipo_mem_req_s mem_req_o;
  ipo_msg_s     msg_o;
  ipo_cpl_s     cpl_in_i = '0, cpl_out_o;
  int           mismatches = 0, tests_run = 0, cycles = 0;
  ipo_engine u_ipo_engine (.*);
  ipo_fabric_model u_ipo_fabric_model (.sys_clk_i, .resetn_i, .lat_i(lat),
    .mem_req_valid_i(mem_req_valid_o), .mem_req_i(mem_req_o), .mem_req_ready_o(mem_req_ready_i),
    .mem_rdata_valid_o(mem_rdata_valid_i), .mem_rdata_o(mem_rdata_i), .mem_go_o(mem_go_i),
    .msg_valid_i(msg_valid_o), .msg_i(msg_o), .msg_ready_o(msg_ready_i), .msg_done_o(msg_done_i));
  always #4 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [511:0] seen, input logic [511:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    do @(posedge sys_clk_i); while (avs_waitrequest_o);
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(posedge sys_clk_i);
  endtask
  task automatic send_irq(input logic posted, input logic urgent_qualifier, input logic [7:0] vec);
    irq_valid_i <= 1'h1;
    irq_i <= '{posted, urgent_qualifier, vec, 58'h1, 32'h0000_00C3};
    do @(posedge sys_clk_i); while (!irq_ready_o);
    irq_valid_i <= 1'h0;
    do @(posedge sys_clk_i); while (!irq_ready_o);
  endtask
  function automatic logic [511:0] desc(logic on, logic sn, logic [7:0] nv, logic [31:0] nd);
    desc = {192'h0, nd, 8'h0, nv, 14'h0, sn, on, 256'h81};
  endfunction
  task automatic t_order();
    int n0;
    n0 = u_ipo_fabric_model.n_rd;
    u_ipo_fabric_model.mem[1] = desc(1'h0, 1'h0, 8'h30, 32'h11);
    pw_issue_i <= 1'h1;
    irq_valid_i <= 1'h1;
    irq_i <= '{1'h1, 1'h0, 8'h05, 58'h1, 32'h0};
    @(posedge sys_clk_i);
    pw_issue_i <= 1'h0;
    irq_valid_i <= 1'h0;
    repeat (20) @(posedge sys_clk_i);
    chk(u_ipo_fabric_model.n_rd - n0, 0);
    pw_done_i <= 1'h1;
    @(posedge sys_clk_i);
    pw_done_i <= 1'h0;
    do @(posedge sys_clk_i); while (!irq_ready_o);
    chk(u_ipo_fabric_model.n_rd - n0, 1);
  endtask
  task automatic t_post();
    logic [3:0]   c [5] = '{4'b0001, 4'b0011, 4'b0100, 4'b0111, 4'b1010};  // on,sn,urg,note
    logic [511:0] d;
    int           n0;
    for (int i = 0; i < 5; i++) begin
      lat <= 8'(2 * i);
      d = desc(c[i][3], c[i][2], 8'h40 + 8'(i), 32'h100 + 32'(i));
      u_ipo_fabric_model.mem[1] = d;
      n0 = u_ipo_fabric_model.n_msg;
      send_irq(1'h1, c[i][1], 8'h10 + 8'(i));
      d[8'h10 + 8'(i)] = 1'h1;
      d[`IPO_ON_BIT] = c[i][3] | c[i][0];
      chk(u_ipo_fabric_model.mem[1], d);
      chk(u_ipo_fabric_model.n_msg - n0, c[i][0]);
      if (c[i][0]) chk(u_ipo_fabric_model.last_msg, {32'h100 + 32'(i), 8'h40 + 8'(i), 6'h01});
    end
  endtask
  task automatic t_regs();
    logic [31:0] q;
    avs(1'h0, 4'h0, 32'h0, q);
    chk(q, 32'h1);
    avs(1'h0, 4'hF, 32'h0, q);
    chk(q, 32'h0);
    avs(1'h0, 4'h2, 32'h0, q);
    chk(q, 32'h6);
    avs(1'h0, 4'h3, 32'h0, q);
    chk(q, 32'h4);
    avs(1'h1, 4'h0, 32'h0, q);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_ready_o, 1'h0);
    avs(1'h1, 4'h0, 32'h3, q);
    avs(1'h0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task automatic t_cpl();
    int d0;
    lat <= 8'h05;
    d0 = u_ipo_fabric_model.n_done;
    irq_valid_i <= 1'h1;
    irq_i <= '{1'h0, 1'h0, 8'h77, 58'h1, 32'h0000_00C3};
    do @(posedge sys_clk_i); while (!irq_ready_o);
    irq_valid_i <= 1'h0;
    cpl_in_valid_i <= 1'h1;
    cpl_in_i <= '{8'h01, 64'h11};
    do @(posedge sys_clk_i); while (!cpl_in_ready_o);
    cpl_in_i <= '{8'h02, 64'h22};
    do @(posedge sys_clk_i); while (!cpl_in_ready_o);
    cpl_in_valid_i <= 1'h0;
    while (u_ipo_fabric_model.n_done == d0) begin
      chk(cpl_out_valid_o, 1'h0);
      chk(irq_ready_o, 1'h0);
      @(posedge sys_clk_i);
    end
    chk(u_ipo_fabric_model.last_msg, {32'hC3, 8'h77, 6'h01});
    repeat (3) @(posedge sys_clk_i);
    for (int t = 1; t < 3; t++) begin
      cpl_out_ready_i <= 1'h1;
      do @(posedge sys_clk_i); while (!cpl_out_valid_o);
      chk(cpl_out_o, {8'(t), 64'(t * 17)});
      cpl_out_ready_i <= 1'h0;
      @(posedge sys_clk_i);
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    t_order();
    t_post();
    t_regs();
    t_cpl();
    close_out();
  end
endmodule // interrupt_posting_ordering_test
